/* shared/jtp_defs.svh */
`ifndef JTP_DEFS_SVH
`define JTP_DEFS_SVH

// instruction register
`define JTP_IR_W         4
`define JTP_IR_CAPTURE   4'h1
`define JTP_IR_IDCODE    4'h1
`define JTP_IR_USER      4'h8
`define JTP_IR_BYPASS    4'hF

// data register widths
`define JTP_DR_W         32
`define JTP_USER_W       8

// reset values
`define JTP_DR_RST       32'h0000_0000
`define JTP_USER_RST     8'h00

`endif

/* shared/jtp_pkg.sv */
`include "jtp_defs.svh"

package jtp_pkg;

    typedef enum logic [3:0] {
        TLR,
        RTI,
        SEL_DR,
        CAP_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPD_DR,
        SEL_IR,
        CAP_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPD_IR
    } jtp_state_t;

    typedef struct packed {
        logic                    valid;
        logic [`JTP_USER_W-1:0]  data;
    } jtp_word_t;

endpackage

/* hw/jtp_tap.sv */
`timescale 1ns/100ps
`include "jtp_defs.svh"
// Functional notes
// - tdi captured on rising tck while shifting
// - tdo updated on falling tck edge
// - tdo released when not shifting out
// - tms sampled on rising tck edge
// - state changes on following falling tck
// - low trst resets tap asynchronously
module jtp_tap #(
    parameter logic [31:0] IDCODE_VALUE = 32'h1234_5671  // arbitrary value
) (
    // system side
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    // test port pins
    input  wire logic                    tck,
    input  wire logic                    tms,
    input  wire logic                    tdi,
    input  wire logic                    trst_n,
    output logic                         tdo_out,
    output logic                         tdo_oe_n,
    // user word from host
    output jtp_pkg::jtp_word_t           user_rx,
    // user word to host
    input  wire logic [`JTP_USER_W-1:0]  user_tx_data,
    input  wire logic                    user_tx_valid,
    output logic                         user_tx_ready,
    // status
    output logic                         link_in_reset
);

    function automatic jtp_pkg::jtp_state_t jtp_next_state(
        input jtp_pkg::jtp_state_t s,
        input logic                m
    );
        case (s)
            jtp_pkg::TLR:      jtp_next_state = m ? jtp_pkg::TLR      : jtp_pkg::RTI;
            jtp_pkg::RTI:      jtp_next_state = m ? jtp_pkg::SEL_DR   : jtp_pkg::RTI;
            jtp_pkg::SEL_DR:   jtp_next_state = m ? jtp_pkg::SEL_IR   : jtp_pkg::CAP_DR;
            jtp_pkg::CAP_DR:   jtp_next_state = m ? jtp_pkg::EXIT1_DR : jtp_pkg::SHIFT_DR;
            jtp_pkg::SHIFT_DR: jtp_next_state = m ? jtp_pkg::EXIT1_DR : jtp_pkg::SHIFT_DR;
            jtp_pkg::EXIT1_DR: jtp_next_state = m ? jtp_pkg::UPD_DR   : jtp_pkg::PAUSE_DR;
            jtp_pkg::PAUSE_DR: jtp_next_state = m ? jtp_pkg::EXIT2_DR : jtp_pkg::PAUSE_DR;
            jtp_pkg::EXIT2_DR: jtp_next_state = m ? jtp_pkg::UPD_DR   : jtp_pkg::SHIFT_DR;
            jtp_pkg::UPD_DR:   jtp_next_state = m ? jtp_pkg::SEL_DR   : jtp_pkg::RTI;
            jtp_pkg::SEL_IR:   jtp_next_state = m ? jtp_pkg::TLR      : jtp_pkg::CAP_IR;
            jtp_pkg::CAP_IR:   jtp_next_state = m ? jtp_pkg::EXIT1_IR : jtp_pkg::SHIFT_IR;
            jtp_pkg::SHIFT_IR: jtp_next_state = m ? jtp_pkg::EXIT1_IR : jtp_pkg::SHIFT_IR;
            jtp_pkg::EXIT1_IR: jtp_next_state = m ? jtp_pkg::UPD_IR   : jtp_pkg::PAUSE_IR;
            jtp_pkg::PAUSE_IR: jtp_next_state = m ? jtp_pkg::EXIT2_IR : jtp_pkg::PAUSE_IR;
            jtp_pkg::EXIT2_IR: jtp_next_state = m ? jtp_pkg::UPD_IR   : jtp_pkg::SHIFT_IR;
            jtp_pkg::UPD_IR:   jtp_next_state = m ? jtp_pkg::SEL_DR   : jtp_pkg::RTI;
            default:           jtp_next_state = jtp_pkg::TLR;
        endcase
    endfunction

    // length of the selected data path depends on the instruction
    function automatic logic [`JTP_DR_W-1:0] jtp_dr_shift(
        input logic [`JTP_IR_W-1:0] ir,
        input logic [`JTP_DR_W-1:0] dr,
        input logic                 din
    );
        case (ir)
            `JTP_IR_IDCODE: jtp_dr_shift = {din, dr[`JTP_DR_W-1:1]};
            `JTP_IR_USER:   jtp_dr_shift = {{(`JTP_DR_W-`JTP_USER_W){1'b0}},
                                            din, dr[`JTP_USER_W-1:1]};
            default:        jtp_dr_shift = {{(`JTP_DR_W-1){1'b0}}, din};
        endcase
    endfunction

    // rising tck state
    logic                    tms_s_reg,    tms_s_next;
    logic [`JTP_IR_W-1:0]    ir_sh_reg,    ir_sh_next;
    logic [`JTP_IR_W-1:0]    ir_reg,       ir_next;
    logic [`JTP_DR_W-1:0]    dr_sh_reg,    dr_sh_next;
    logic [`JTP_USER_W-1:0]  upd_data_reg, upd_data_next;
    logic                    upd_tgl_reg,  upd_tgl_next;
    logic                    txs1_reg,     txs2_reg,      txs3_reg;
    logic [`JTP_USER_W-1:0]  tx_hold_reg,  tx_hold_next;
    logic                    ack_tgl_reg,  ack_tgl_next;
    // falling tck state
    jtp_pkg::jtp_state_t     state_reg,    state_next;
    logic                    tdo_reg,      tdo_next;
    logic                    tdo_oe_n_reg, tdo_oe_n_next;
    // registered here so only one clean bit crosses to sys_clk
    logic                    tlr_reg,      tlr_next;
    // system clock state
    logic                    rxs1_reg,     rxs2_reg,      rxs3_reg;
    logic [`JTP_USER_W-1:0]  rx_data_reg,  rx_data_next;
    logic                    rx_valid_reg, rx_valid_next;
    logic [`JTP_USER_W-1:0]  tx_data_reg,  tx_data_next;
    logic                    tx_tgl_reg,   tx_tgl_next;
    logic                    acks1_reg,    acks2_reg;
    logic                    busy_reg,     busy_next;
    logic                    tlrs1_reg,    tlrs2_reg;
    logic                    in_tlr_reg,   in_tlr_next;

    always_comb begin
        tms_s_next    = tms;
        ir_sh_next    = ir_sh_reg;
        ir_next       = ir_reg;
        dr_sh_next    = dr_sh_reg;
        upd_data_next = upd_data_reg;
        upd_tgl_next  = upd_tgl_reg;
        tx_hold_next  = tx_hold_reg;
        ack_tgl_next  = ack_tgl_reg;
        // tx word stable while sys side is busy, so copy after sync
        if (txs2_reg != txs3_reg) begin
            tx_hold_next = tx_data_reg;
            ack_tgl_next = txs2_reg;
        end
        case (state_reg)
            jtp_pkg::TLR: begin
                ir_next = `JTP_IR_IDCODE;
            end
            jtp_pkg::CAP_IR: begin
                ir_sh_next = `JTP_IR_CAPTURE;
            end
            jtp_pkg::SHIFT_IR: begin
                ir_sh_next = {tdi, ir_sh_reg[`JTP_IR_W-1:1]};
            end
            jtp_pkg::UPD_IR: begin
                ir_next = ir_sh_reg;
            end
            jtp_pkg::CAP_DR: begin
                case (ir_reg)
                    `JTP_IR_IDCODE: dr_sh_next = IDCODE_VALUE;
                    `JTP_IR_USER:   dr_sh_next = {{(`JTP_DR_W-`JTP_USER_W){1'b0}},
                                                  tx_hold_reg};
                    default:        dr_sh_next = `JTP_DR_RST;
                endcase
            end
            jtp_pkg::SHIFT_DR: begin
                dr_sh_next = jtp_dr_shift(ir_reg, dr_sh_reg, tdi);
            end
            jtp_pkg::UPD_DR: begin
                if (ir_reg == `JTP_IR_USER) begin
                    upd_data_next = dr_sh_reg[`JTP_USER_W-1:0];
                    upd_tgl_next  = ~upd_tgl_reg;
                end
            end
            default: begin
                ir_sh_next = ir_sh_reg;
            end
        endcase
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tms_s_reg    <= 1'b1;
            ir_sh_reg    <= `JTP_IR_CAPTURE;
            ir_reg       <= `JTP_IR_IDCODE;
            dr_sh_reg    <= `JTP_DR_RST;
            upd_data_reg <= `JTP_USER_RST;
            upd_tgl_reg  <= 1'b0;
            txs1_reg     <= 1'b0;
            txs2_reg     <= 1'b0;
            txs3_reg     <= 1'b0;
            tx_hold_reg  <= `JTP_USER_RST;
            ack_tgl_reg  <= 1'b0;
        end else begin
            tms_s_reg    <= tms_s_next;
            ir_sh_reg    <= ir_sh_next;
            ir_reg       <= ir_next;
            dr_sh_reg    <= dr_sh_next;
            upd_data_reg <= upd_data_next;
            upd_tgl_reg  <= upd_tgl_next;
            txs1_reg     <= tx_tgl_reg;
            txs2_reg     <= txs1_reg;
            txs3_reg     <= txs2_reg;
            tx_hold_reg  <= tx_hold_next;
            ack_tgl_reg  <= ack_tgl_next;
        end
    end

    // state moves half a tck after tms was sampled
    always_comb begin
        state_next    = jtp_next_state(state_reg, tms_s_reg);
        tdo_next      = tdo_reg;
        tdo_oe_n_next = 1'b1;
        tlr_next      = (state_next == jtp_pkg::TLR);
        if (state_next == jtp_pkg::SHIFT_IR) begin
            tdo_next      = ir_sh_reg[0];
            tdo_oe_n_next = 1'b0;
        end else if (state_next == jtp_pkg::SHIFT_DR) begin
            tdo_next      = dr_sh_reg[0];
            tdo_oe_n_next = 1'b0;
        end
    end

    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            state_reg    <= jtp_pkg::TLR;
            tdo_reg      <= 1'b0;
            tdo_oe_n_reg <= 1'b1;
            tlr_reg      <= 1'b1;
        end else begin
            state_reg    <= state_next;
            tdo_reg      <= tdo_next;
            tdo_oe_n_reg <= tdo_oe_n_next;
            tlr_reg      <= tlr_next;
        end
    end

    // system clock side; rx toggle edge found on synced stages only
    always_comb begin
        rx_data_next  = rx_data_reg;
        rx_valid_next = 1'b0;
        tx_data_next  = tx_data_reg;
        tx_tgl_next   = tx_tgl_reg;
        busy_next     = busy_reg;
        in_tlr_next   = tlrs2_reg;
        if (rxs2_reg != rxs3_reg) begin
            rx_data_next  = upd_data_reg;
            rx_valid_next = 1'b1;
        end
        if (busy_reg && (acks2_reg == tx_tgl_reg)) begin
            busy_next = 1'b0;
        end
        if (user_tx_valid && !busy_reg) begin
            tx_data_next = user_tx_data;
            tx_tgl_next  = ~tx_tgl_reg;
            busy_next    = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rxs1_reg     <= 1'b0;
            rxs2_reg     <= 1'b0;
            rxs3_reg     <= 1'b0;
            rx_data_reg  <= `JTP_USER_RST;
            rx_valid_reg <= 1'b0;
            tx_data_reg  <= `JTP_USER_RST;
            tx_tgl_reg   <= 1'b0;
            acks1_reg    <= 1'b0;
            acks2_reg    <= 1'b0;
            busy_reg     <= 1'b0;
            tlrs1_reg    <= 1'b1;
            tlrs2_reg    <= 1'b1;
            in_tlr_reg   <= 1'b1;
        end else begin
            rxs1_reg     <= upd_tgl_reg;
            rxs2_reg     <= rxs1_reg;
            rxs3_reg     <= rxs2_reg;
            rx_data_reg  <= rx_data_next;
            rx_valid_reg <= rx_valid_next;
            tx_data_reg  <= tx_data_next;
            tx_tgl_reg   <= tx_tgl_next;
            acks1_reg    <= ack_tgl_reg;
            acks2_reg    <= acks1_reg;
            busy_reg     <= busy_next;
            tlrs1_reg    <= tlr_reg;
            tlrs2_reg    <= tlrs1_reg;
            in_tlr_reg   <= in_tlr_next;
        end
    end

    assign tdo_out       = tdo_reg;
    assign tdo_oe_n      = tdo_oe_n_reg;
    assign user_rx.valid = rx_valid_reg;
    assign user_rx.data  = rx_data_reg;
    assign user_tx_ready = !busy_reg;
    assign link_in_reset = in_tlr_reg;

    // host test pins idle during configuration is the host's duty

    property p_tms_sample;
        @(posedge tck) disable iff (!trst_n)
        ##1 tms_s_reg == $past(tms);
    endproperty
    a_tms_sample: assert property (p_tms_sample) else $error("tms not sampled on rise");

    property p_ir_capture_tdi;
        @(posedge tck) disable iff (!trst_n)
        (state_reg == jtp_pkg::SHIFT_IR) |=> ir_sh_reg[`JTP_IR_W-1] == $past(tdi);
    endproperty
    a_ir_capture_tdi: assert property (p_ir_capture_tdi) else $error("ir tdi bit lost");

    property p_user_capture_tdi;
        @(posedge tck) disable iff (!trst_n)
        (state_reg == jtp_pkg::SHIFT_DR && ir_reg == `JTP_IR_USER)
            |=> dr_sh_reg[`JTP_USER_W-1] == $past(tdi) && $stable(ir_reg);
    endproperty
    a_user_capture_tdi: assert property (p_user_capture_tdi) else $error("dr tdi bit lost");

    property p_tdo_lsb;
        @(posedge tck) disable iff (!trst_n)
        (state_reg == jtp_pkg::SHIFT_DR) |-> !tdo_oe_n && tdo_out == dr_sh_reg[0];
    endproperty
    a_tdo_lsb: assert property (p_tdo_lsb) else $error("tdo not shifted lsb");

    property p_tdo_release;
        @(posedge tck) disable iff (!trst_n)
        !(state_reg inside {jtp_pkg::SHIFT_DR, jtp_pkg::SHIFT_IR}) |-> tdo_oe_n;
    endproperty
    a_tdo_release: assert property (p_tdo_release) else $error("tdo driven while idle");

    property p_state_on_fall;
        @(posedge tck) disable iff (!trst_n)
        ($past(state_reg) == jtp_pkg::SEL_DR && !tms_s_reg) ##0 $past(trst_n)
            |-> state_reg == jtp_pkg::CAP_DR;
    endproperty
    a_state_on_fall: assert property (p_state_on_fall) else $error("bad select-dr move");

    property p_five_ones;
        @(posedge tck) disable iff (!trst_n)
        tms_s_reg [*5] |-> state_reg == jtp_pkg::TLR;
    endproperty
    a_five_ones: assert property (p_five_ones) else $error("five ones not in reset");

    // tck is still while trst is low, so watch it from sys_clk
    property p_trst_reset;
        @(posedge sys_clk) disable iff (!rst_n)
        !trst_n |-> state_reg == jtp_pkg::TLR && tdo_oe_n && ir_reg == `JTP_IR_IDCODE;
    endproperty
    a_trst_reset: assert property (p_trst_reset) else $error("trst did not reset tap");

endmodule

/* sim/jtp_host.sv */
`timescale 1ns/100ps
module jtp_host (
    // test port pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    input  wire logic tdo_out,
    input  wire logic tdo_oe_n
);
    logic tdo_last;
    logic tdo_pin;
    logic oe_mid;
    logic oe_rst;

    // no pull on tdo: a released pin shows the inverse of its last level
    always @(tdo_out or tdo_oe_n) if (!tdo_oe_n) tdo_last = tdo_out;
    assign tdo_pin = tdo_oe_n ? ~tdo_last : tdo_out;

    // pins held still until asked; tck rests low like its pull-down
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b1;  // rests high like its pull-up; first reset gives a real edge
        tdo_last = 1'b0;
    end

    task automatic step(input logic m, input logic d, output logic o);
        tms = m;  // set up 2 ns before the rise
        tdi = d;
        #2 o = tdo_pin;
        tck = 1'b1;
        #1 oe_mid = tdo_oe_n;
        #2 tck = 1'b0;
        #1;  // return after the fall has settled tdo and its enable
    endtask

    task automatic idle(input int n);
        logic o;
        repeat (n) step(1'b0, 1'b1, o);
    endtask

    task automatic enter(input logic is_ir);
        logic o;
        step(1'b1, 1'b1, o);
        if (is_ir) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask

    task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout, output logic oe_pre, output logic oe_in);
        logic o;
        enter(is_ir);
        oe_pre = oe_mid;
        oe_in = tdo_oe_n;
        dout = 32'h0000_0000;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask

    task automatic five_ones();
        logic o;
        repeat (5) step(1'b1, 1'b1, o);
    endtask

    task automatic reset_async();
        trst_n = 1'b0;
        #25 oe_rst = tdo_oe_n;  // trst low 50 ns in all, long enough to span a sys_clk edge
        #25 tms = 1'b1;  // tms high and tck still while leaving reset
        trst_n = 1'b1;
    endtask
endmodule

/* sim/tb_jtp_tap.sv */
`timescale 1ns/100ps
`include "jtp_defs.svh"
module tb_jtp_tap;
    localparam logic [31:0] ID = 32'h1234_5671;  // arbitrary value
    logic                   sys_clk, rst_n, tck, tms, tdi, trst_n, tdo_out, tdo_oe_n;
    logic [`JTP_USER_W-1:0] user_tx_data;
    logic                   user_tx_valid, user_tx_ready, link_in_reset;
    jtp_pkg::jtp_word_t     user_rx;
    logic [31:0]            dout;
    logic                   oe_pre, oe_in;
    int                     mismatches, n_compared;

    jtp_tap #(.IDCODE_VALUE(ID)) u_jtp_tap (.sys_clk(sys_clk), .rst_n(rst_n), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
        .user_rx(user_rx), .user_tx_data(user_tx_data), .user_tx_valid(user_tx_valid),
        .user_tx_ready(user_tx_ready), .link_in_reset(link_in_reset));
    jtp_host u_jtp_host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n));

    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    task automatic stop_test();
        if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk_bit(input string nm, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
        end
    endtask

    task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic sys_wait(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // id word after async reset, enable timing around the shift
    task automatic t_idcode();
        u_jtp_host.reset_async();
        chk_bit("oe_n after trst", 1'b1, tdo_oe_n);
        sys_wait(6);
        chk_bit("in_reset", 1'b1, link_in_reset);
        u_jtp_host.idle(1);
        sys_wait(6);
        chk_bit("left reset", 1'b0, link_in_reset);
        u_jtp_host.scan(1'b0, 32, 32'h0000_0000, dout, oe_pre, oe_in);
        chk_word("idcode", ID, dout);
        chk_bit("oe_n before fall", 1'b1, oe_pre);
        chk_bit("oe_n in shift", 1'b0, oe_in);
        chk_bit("oe_n idle", 1'b1, tdo_oe_n);
    endtask

    // user word both ways, a refused request while busy
    task automatic t_user(input logic [7:0] tx_w, input logic [7:0] rx_w);
        u_jtp_host.scan(1'b1, 4, 32'h0000_0008, dout, oe_pre, oe_in);
        chk_word("ir capture", 32'h0000_0001, dout);
        sys_wait(1);
        user_tx_data = tx_w;
        user_tx_valid = 1'b1;
        sys_wait(1);
        user_tx_data = ~tx_w;
        chk_bit("ready dropped", 1'b0, user_tx_ready);
        sys_wait(1);
        user_tx_valid = 1'b0;
        for (int i = 0; i < 20 && user_tx_ready !== 1'b1; i++) begin
            u_jtp_host.idle(4);
            sys_wait(2);
        end
        chk_bit("ready back", 1'b1, user_tx_ready);
        u_jtp_host.scan(1'b0, 8, {24'h00_0000, rx_w}, dout, oe_pre, oe_in);
        chk_word("user out", {24'h00_0000, tx_w}, dout);
        for (int i = 0; i < 20 && user_rx.valid !== 1'b1; i++) sys_wait(1);
        chk_bit("rx valid", 1'b1, user_rx.valid);
        chk_word("rx data", {24'h00_0000, rx_w}, {24'h00_0000, user_rx.data});
        sys_wait(1);
        chk_bit("rx pulse", 1'b0, user_rx.valid);
    endtask

    // bypass and an unknown code both give one zero bit of delay
    task automatic t_bypass();
        logic [3:0] codes [2] = '{4'hF, 4'h5};
        foreach (codes[k]) begin
            u_jtp_host.scan(1'b1, 4, {28'h000_0000, codes[k]}, dout, oe_pre, oe_in);
            u_jtp_host.scan(1'b0, 9, 32'h0000_015A, dout, oe_pre, oe_in);
            chk_word("bypass", 32'h0000_00B4, dout & 32'h0000_01FF);
        end
    endtask

    // five ones from mid-shift, then async reset with tck still
    task automatic t_resets();
        u_jtp_host.enter(1'b0);
        u_jtp_host.five_ones();
        sys_wait(6);
        chk_bit("five ones", 1'b1, link_in_reset);
        u_jtp_host.idle(1);
        u_jtp_host.scan(1'b0, 32, 32'h0000_0000, dout, oe_pre, oe_in);
        chk_word("ir reset", ID, dout);
        u_jtp_host.enter(1'b0);
        chk_bit("driving", 1'b0, tdo_oe_n);
        u_jtp_host.reset_async();
        chk_bit("async release", 1'b1, u_jtp_host.oe_rst);
        u_jtp_host.idle(1);
        u_jtp_host.scan(1'b0, 32, 32'h0000_0000, dout, oe_pre, oe_in);
        chk_word("after trst", ID, dout);
    endtask

    initial begin
        mismatches = 0;
        n_compared = 0;
        rst_n = 1'b0;
        user_tx_data = 8'h00;
        user_tx_valid = 1'b0;
        sys_wait(2);
        rst_n = 1'b1;
        sys_wait(1);
        chk_bit("ready reset", 1'b1, user_tx_ready);
        t_idcode();
        t_user(8'h3C, 8'hA5);
        t_user(8'hC3, 8'h5A);
        t_bypass();
        t_resets();
        stop_test();
    end

    // whole run is a few microseconds
    initial begin
        #200000;
        mismatches++;
        stop_test();
    end
endmodule
